/* mic_core_model.sv */
`timescale 1ns/10ps
`default_nettype none
module mic_core_model (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic irqReq,
	input wire logic [1:0] ackDelay,
	output logic intAck
);
	logic [1:0] waitCnt;
	logic go;
	assign go = irqReq && !intAck;
	// one acknowledge per raised request, ackDelay+1 cycles after irqReq rises
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			intAck <= 1'h0;
			waitCnt <= 2'h0;
		end else begin
			intAck <= go && waitCnt == ackDelay;
			waitCnt <= (go && waitCnt != ackDelay) ? waitCnt + 2'h1 : 2'h0;
		end
	end
endmodule : mic_core_model
`default_nettype wire

/* mic_interrupt_controller.sv */
// Operation
// - Bit 0 of 8-bit control register globally enables interrupts.
// - 8-bit mask register, one bit per module 0 to 5.
// - Module 0 external, 1 SPI/I2C, 3 timers 0-3, 4 timers 4-6, 5 none.
// - Line modem, data manager, DES and serial requests go to module 2.
// - 16-bit vector register gives handler start address.
// - Each module has per-source enable registers.
// - Module 2 has nine separate source flags.
// - Module 3 has one flag per timer 0 to 3.
`timescale 1ns/10ps
`default_nettype none
`include "mic_params.svh"

module mic_interrupt_controller (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic extIrq,
	input wire logic spiIrq,
	input wire logic i2cIrq,
	input wire logic serRxIrq,
	input wire logic serTxIrq,
	input wire logic modemRxIrq,
	input wire logic modemTxIrq,
	input wire logic dmTxIrq,
	input wire logic dmRxIrq,
	input wire logic desIrq,
	input wire logic carrierIrq,
	input wire logic ackIrq,
	input wire logic [3:0] timerLoIrq,
	input wire logic [2:0] timerHiIrq,
	input wire logic [7:0] regAddr,
	input wire logic [15:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	output logic [15:0] regRdata,
	input wire logic intAck,
	output logic irqReq,
	output logic [2:0] irqModule,
	output logic [15:0] vectorAddr,
	output logic irqOut
);
	typedef logic [`MIC_SRC_W-1:0] src_t;

	logic [7:0] globalInterruptControl_r;
	logic [7:0] moduleInterruptMask_r;
	logic [15:0] handlerVectorAddress_r;
	logic [15:0] regRdata_r;

	// per-module source pulses, padded to common width
	src_t srcPulse [`MIC_NUM_MOD];
	src_t srcEnable [`MIC_NUM_MOD];
	src_t srcFlags [`MIC_NUM_MOD];
	logic [`MIC_NUM_MOD-1:0] modActive;
	wire logic [`MIC_SRC_W-1:0] modemGroupPulse;

	// module 2 flag bit per source
	assign modemGroupPulse[`MIC_M2_SER_RX] = serRxIrq;
	assign modemGroupPulse[`MIC_M2_SER_TX] = serTxIrq;
	assign modemGroupPulse[`MIC_M2_PHY_RX] = modemRxIrq;
	assign modemGroupPulse[`MIC_M2_PHY_TX] = modemTxIrq;
	assign modemGroupPulse[`MIC_M2_DM_TX] = dmTxIrq;
	assign modemGroupPulse[`MIC_M2_DM_RX] = dmRxIrq;
	assign modemGroupPulse[`MIC_M2_DES] = desIrq;
	assign modemGroupPulse[`MIC_M2_CS] = carrierIrq;
	assign modemGroupPulse[`MIC_M2_ACK] = ackIrq;

	assign srcPulse[0] = {8'h00, extIrq};
	assign srcPulse[1] = {7'h00, i2cIrq, spiIrq};
	assign srcPulse[2] = modemGroupPulse;
	assign srcPulse[3] = {5'h00, timerLoIrq};
	assign srcPulse[4] = {6'h00, timerHiIrq};
	assign srcPulse[5] = '0;

	wire logic isGctl = regAddr == `MIC_ADDR_GCTL;
	wire logic isMask = regAddr == `MIC_ADDR_MMASK;
	wire logic isVec = regAddr == `MIC_ADDR_VEC;
	wire logic isPend = regAddr == `MIC_ADDR_PEND;
	wire logic [7:0] enIdx = regAddr - `MIC_ADDR_SRC_EN0;
	wire logic [7:0] flIdx = regAddr - `MIC_ADDR_SRC_FLG0;
	wire logic isEn = (regAddr >= `MIC_ADDR_SRC_EN0) && (enIdx < 8'(`MIC_NUM_MOD));
	wire logic isFl = (regAddr >= `MIC_ADDR_SRC_FLG0) && (flIdx < 8'(`MIC_NUM_MOD));

	// write strobes, one per register
	wire logic wrGctl = regWr & isGctl;
	wire logic wrMask = regWr & isMask;
	wire logic wrVec = regWr & isVec;
	wire logic [`MIC_NUM_MOD-1:0] wrEn;
	wire logic [`MIC_NUM_MOD-1:0] wrFl;

	// per-module read words
	wire logic [15:0] enWord [`MIC_NUM_MOD];
	wire logic [15:0] flWord [`MIC_NUM_MOD];

	wire logic globalEn = globalInterruptControl_r[`MIC_GIE_BIT];
	// three-level gating, one bit per module
	wire logic [`MIC_NUM_MOD-1:0] modReq;

	genvar m;
	generate
		for (m = 0; m < `MIC_NUM_MOD; m++) begin : g_mod
			assign wrEn[m] = regWr & isEn & (enIdx == 8'(m));
			assign wrFl[m] = regWr & isFl & (flIdx == 8'(m));
			assign enWord[m] = {7'h00, srcEnable[m]};
			assign flWord[m] = {7'h00, srcFlags[m]};
			assign modReq[m] = modActive[m] & moduleInterruptMask_r[m] & globalEn;

			mic_source_group #(
				.WIDTH(`MIC_SRC_W)
			) u_group (
				.core_clk(core_clk),
				.rst(rst),
				.srcPulse(srcPulse[m]),
				.enWrite(wrEn[m]),
				.flagWrite(wrFl[m]),
				.wrData(regWdata[`MIC_SRC_W-1:0]),
				.enable(srcEnable[m]),
				.flags(srcFlags[m]),
				.active(modActive[m])
			);
		end
	endgenerate

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			globalInterruptControl_r <= `MIC_GCTL_RST;
		end else if (wrGctl) begin
			globalInterruptControl_r <= regWdata[7:0];
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			moduleInterruptMask_r <= `MIC_MMASK_RST;
		end else if (wrMask) begin
			moduleInterruptMask_r <= regWdata[7:0];
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			handlerVectorAddress_r <= `MIC_VEC_RST;
		end else if (wrVec) begin
			handlerVectorAddress_r <= regWdata;
		end
	end

	// read-back words, upper bits zero except the full 16-bit vector word
	wire logic [15:0] rdGctl = {8'h00, globalInterruptControl_r};
	wire logic [15:0] rdMask = {8'h00, moduleInterruptMask_r};
	wire logic [15:0] rdPend = {10'h000, modReq};
	wire logic [15:0] enSel = isEn ? enWord[enIdx[2:0]] : 16'h0000;
	wire logic [15:0] flSel = isFl ? flWord[flIdx[2:0]] : 16'h0000;
	wire logic [15:0] rdMux =
		isGctl ? rdGctl :
		isMask ? rdMask :
		isVec ? handlerVectorAddress_r :
		isPend ? rdPend :
		isEn ? enSel :
		isFl ? flSel : 16'h0000;

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			regRdata_r <= 16'h0000;
		end else begin
			regRdata_r <= regRd ? rdMux : 16'h0000;
		end
	end

	mic_vector_unit u_vector (
		.core_clk(core_clk),
		.rst(rst),
		.modReq(modReq),
		.intAck(intAck),
		.irqReq(irqReq),
		.irqModule(irqModule)
	);

	assign regRdata = regRdata_r;
	assign vectorAddr = handlerVectorAddress_r;
	assign irqOut = |modReq;
endmodule : mic_interrupt_controller

`default_nettype wire

/* mic_interrupt_controller_asserts.sv */
`timescale 1ns/10ps
`default_nettype none
module mic_irq_chk (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [7:0] regAddr,
	input wire logic [15:0] regWdata,
	input wire logic regWr,
	input wire logic intAck,
	input wire logic irqReq,
	input wire logic [2:0] irqModule,
	input wire logic [15:0] vectorAddr,
	input wire logic irqOut
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	gie_off_a: assert property (regWr && regAddr == 8'h00 && !regWdata[0] |=> !irqOut)
		else $error("gie");
	mask_off_a: assert property (regWr && regAddr == 8'h01 && regWdata[5:0] == 6'h00 |=> !irqOut)
		else $error("mask");
	no_mod_five_a: assert property (irqReq |-> irqModule < 3'h5) else $error("mod5");
	req_gated_a: assert property (irqReq |-> irqOut && $past(irqOut)) else $error("gated");
	req_rise_a: assert property ($rose(irqReq) |-> $past(irqOut)) else $error("rise");
	mod_held_a: assert property (irqReq && $past(irqReq) |-> $stable(irqModule))
		else $error("held");
	ack_drop_a: assert property (irqReq && intAck |=> !irqReq) else $error("ack");
	vec_write_a: assert property ($changed(vectorAddr) |-> $past(regWr) && $past(regAddr) == 8'h02)
		else $error("vec");
endmodule : mic_irq_chk
bind mic_interrupt_controller mic_irq_chk i_chk (.core_clk, .rst, .regAddr, .regWdata, .regWr,
	.intAck, .irqReq, .irqModule, .vectorAddr, .irqOut);
`default_nettype wire

/* mic_interrupt_controller_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module mic_interrupt_controller_tb_top;
	logic core_clk, rst, regWr, regRd, intAck, irqReq, irqOut;
	logic [18:0] src;
	logic [7:0] regAddr;
	logic [15:0] regWdata, regRdata, vectorAddr;
	logic [2:0] irqModule;
	logic [1:0] ackDelay;
	int n_errors, total_checks;
	// {module, flag bit} per source, in src order
	logic [7:0] rows [19] = '{8'h00, 8'h10, 8'h11, 8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h25,
		8'h26, 8'h27, 8'h28, 8'h30, 8'h31, 8'h32, 8'h33, 8'h40, 8'h41, 8'h42};
	mic_interrupt_controller i_dut (.core_clk, .rst, .extIrq(src[0]), .spiIrq(src[1]),
		.i2cIrq(src[2]), .serRxIrq(src[3]), .serTxIrq(src[4]), .modemRxIrq(src[5]),
		.modemTxIrq(src[6]), .dmTxIrq(src[7]), .dmRxIrq(src[8]), .desIrq(src[9]),
		.carrierIrq(src[10]), .ackIrq(src[11]), .timerLoIrq(src[15:12]),
		.timerHiIrq(src[18:16]), .regAddr, .regWdata, .regWr, .regRd, .regRdata, .intAck,
		.irqReq, .irqModule, .vectorAddr, .irqOut);
	mic_core_model i_core (.core_clk, .rst, .irqReq, .ackDelay, .intAck);
	initial begin
		core_clk = 1'h0;
		forever #50 core_clk = ~core_clk;
	end
	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic io(input logic e);
		#1 chk("irqOut", {15'h0, irqOut}, {15'h0, e});
	endtask : io
	task automatic cyc(input logic w, input logic [7:0] a, input logic [15:0] d);
		@(posedge core_clk);
		regWr <= w;
		regRd <= !w;
		regAddr <= a;
		regWdata <= d;
		@(posedge core_clk);
		regWr <= 1'h0;
		regRd <= 1'h0;
		#1 if (!w) chk("rdata", regRdata, d);
	endtask : cyc
	task automatic end_sim;
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : end_sim
	initial begin
		int k;
		logic [7:0] fa;
		rst = 1'h1;
		src = '0;
		{regWr, regRd, regAddr, regWdata, ackDelay} = '0;
		repeat (3) @(posedge core_clk);
		rst <= 1'h0;
		cyc(1, 8'h00, 16'h0001);
		cyc(1, 8'h01, 16'h003F);
		for (int m = 0; m < 6; m++) cyc(1, 8'h10 + m[7:0], 16'h01FF);
		for (int i = 0; i < 19; i++) begin
			fa = 8'h18 + {4'h0, rows[i][7:4]};
			ackDelay <= i[1:0];
			@(posedge core_clk);
			src[i] <= 1'h1;
			@(posedge core_clk);
			src[i] <= 1'h0;
			io(1);
			cyc(0, 8'h03, 16'h1 << rows[i][7:4]);
			cyc(0, fa, 16'h1 << rows[i][3:0]);
			for (k = 0; k < 20 && irqReq !== 1'h1; k++) begin
				@(posedge core_clk);
				#1;
			end
			#1 chk("irqModule", {13'h0, irqModule}, {9'h0, rows[i][7:4]});
			if (k == 20) begin
				n_errors++;
				end_sim();
			end
			cyc(1, fa, 16'h1 << rows[i][3:0]);
			io(0);
			$display("row %0d done", i);
		end
		cyc(1, 8'h00, 16'h0000);
		@(posedge core_clk);
		src[12] <= 1'h1;
		@(posedge core_clk);
		src[12] <= 1'h0;
		io(0);
		cyc(1, 8'h00, 16'h0001);
		io(1);
		cyc(1, 8'h01, 16'h0037);
		io(0);
		cyc(1, 8'h01, 16'h003F);
		cyc(1, 8'h13, 16'h01FE);
		io(0);
		cyc(1, 8'h02, 16'hA5C3);
		chk("vectorAddr", vectorAddr, 16'hA5C3);
		cyc(1, 8'h07, 16'hFFFF);
		cyc(0, 8'h07, 16'h0000);
		cyc(1, 8'h01, 16'h0000);
		$display("gating done");
		@(posedge core_clk);
		rst <= 1'h1;
		repeat (3) @(posedge core_clk);
		rst <= 1'h0;
		cyc(0, 8'h00, 16'h0000);
		cyc(0, 8'h02, 16'h0000);
		cyc(0, 8'h1B, 16'h0000);
		io(0);
		$display("reset done");
		end_sim();
	end
endmodule : mic_interrupt_controller_tb_top
`default_nettype wire

/* mic_params.svh */
`ifndef MIC_PARAMS_SVH
`define MIC_PARAMS_SVH

// register word addresses
`define MIC_ADDR_GCTL 8'h00
`define MIC_ADDR_MMASK 8'h01
`define MIC_ADDR_VEC 8'h02
`define MIC_ADDR_PEND 8'h03
`define MIC_ADDR_SRC_EN0 8'h10
`define MIC_ADDR_SRC_FLG0 8'h18

// field positions
`define MIC_GIE_BIT 0
`define MIC_NUM_MOD 6
`define MIC_SRC_W 9

// reset values
`define MIC_GCTL_RST 8'h00
`define MIC_MMASK_RST 8'h00
`define MIC_VEC_RST 16'h0000

// module 2 source bit positions
`define MIC_M2_SER_RX 0
`define MIC_M2_SER_TX 1
`define MIC_M2_PHY_RX 2
`define MIC_M2_PHY_TX 3
`define MIC_M2_DM_TX 4
`define MIC_M2_DM_RX 5
`define MIC_M2_DES 6
`define MIC_M2_CS 7
`define MIC_M2_ACK 8

`endif

/* mic_pkg.sv */
`default_nettype none
package mic_pkg;
	typedef logic [7:0] mic_addr_t;
	typedef logic [15:0] mic_data_t;
	typedef logic [8:0] mic_src_t;
	typedef enum logic [1:0] {
		MIC_IDLE = 2'b00,
		MIC_REQ = 2'b01,
		MIC_ACKD = 2'b11
	} mic_state_e;
endpackage : mic_pkg
`default_nettype wire

/* mic_source_group.sv */
`timescale 1ns/10ps
`default_nettype none
`include "mic_params.svh"

module mic_source_group #(
	parameter int WIDTH = 9
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [WIDTH-1:0] srcPulse,
	input wire logic enWrite,
	input wire logic flagWrite,
	input wire logic [WIDTH-1:0] wrData,
	output logic [WIDTH-1:0] enable,
	output logic [WIDTH-1:0] flags,
	output logic active
);
	logic [WIDTH-1:0] enable_r;
	logic [WIDTH-1:0] flags_r;

	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			// set wins over write-one-to-clear
			wire logic flagNxt = srcPulse[i] | (flags_r[i] & ~(flagWrite & wrData[i]));
			always_ff @(posedge core_clk or posedge rst) begin
				if (rst) begin
					flags_r[i] <= 1'b0;
				end else begin
					flags_r[i] <= flagNxt;
				end
			end
		end
	endgenerate

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			enable_r <= '0;
		end else if (enWrite) begin
			enable_r <= wrData;
		end
	end

	assign enable = enable_r;
	assign flags = flags_r;
	assign active = |(flags_r & enable_r);
endmodule : mic_source_group

`default_nettype wire

/* mic_vector_unit.sv */
`timescale 1ns/10ps
`default_nettype none
`include "mic_params.svh"

module mic_vector_unit (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [`MIC_NUM_MOD-1:0] modReq,
	input wire logic intAck,
	output logic irqReq,
	output logic [2:0] irqModule
);
	mic_pkg::mic_state_e state_r;
	mic_pkg::mic_state_e state_nxt;
	logic [2:0] mod_r;
	logic [2:0] firstMod;
	wire logic anyReq = |modReq;
	// capture only on entry so the dispatched module stays put
	wire logic enterReq = (state_r != mic_pkg::MIC_REQ) && (state_nxt == mic_pkg::MIC_REQ);

	always_comb begin
		firstMod = 3'h0;
		for (int k = `MIC_NUM_MOD - 1; k >= 0; k--) begin
			if (modReq[k]) begin
				firstMod = 3'(k);
			end
		end
	end

	always_comb begin
		case (state_r)
			mic_pkg::MIC_IDLE: state_nxt = anyReq ? mic_pkg::MIC_REQ : mic_pkg::MIC_IDLE;
			mic_pkg::MIC_REQ: begin
				if (!anyReq) begin
					state_nxt = mic_pkg::MIC_IDLE;
				end else if (intAck) begin
					state_nxt = mic_pkg::MIC_ACKD;
				end else begin
					state_nxt = mic_pkg::MIC_REQ;
				end
			end
			mic_pkg::MIC_ACKD: state_nxt = mic_pkg::MIC_IDLE;
			default: state_nxt = mic_pkg::MIC_IDLE;
		endcase
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			state_r <= mic_pkg::MIC_IDLE;
			mod_r <= 3'h0;
		end else begin
			state_r <= state_nxt;
			if (enterReq) begin
				mod_r <= firstMod;
			end
		end
	end

	assign irqReq = (state_r == mic_pkg::MIC_REQ) & anyReq;
	assign irqModule = mod_r;
endmodule : mic_vector_unit

`default_nettype wire
